// File: hw/hwp_pkg.sv
package hwp_pkg;
   // Host bus widths
   localparam int HWP_DATA_W  = 32;
   localparam int HWP_ADDR_W  = 7;   // A[7:1]
   localparam int HWP_HALF_W  = 16;
   // Field positions inside the A[7:1] vector (bit 0 is A1)
   localparam int HWP_WSEL_LO = 0;   // A[2:1]
   localparam int HWP_WSEL_HI = 1;
   localparam int HWP_REG_LO  = 2;   // A[7:3]
   localparam int HWP_REG_HI  = 6;
   localparam int HWP_WSEL_W  = HWP_WSEL_HI - HWP_WSEL_LO + 1;
   localparam int HWP_REG_W   = HWP_REG_HI - HWP_REG_LO + 1;
   // Pin timing, ns
   localparam int HWP_CLK_NS  = 20;
   localparam int HWP_TCSL_NS = 32;
   localparam int HWP_TCSH_NS = 13;
   // Least times round up
   localparam int HWP_TCSL_CYC = (HWP_TCSL_NS + HWP_CLK_NS - 1) / HWP_CLK_NS;
   localparam int HWP_TCSH_CYC = (HWP_TCSH_NS + HWP_CLK_NS - 1) / HWP_CLK_NS;
   // Synchroniser depth and reset values
   localparam int HWP_SYNC_N      = 3;
   localparam logic HWP_PIN_IDLE  = 1'b1;

   typedef struct packed {
      logic [HWP_ADDR_W-1:0] addr;
      logic                  fifo_sel;
      logic [HWP_DATA_W-1:0] data;
   } hwp_bus_s;

   typedef struct packed {
      logic                  fifo;
      logic [HWP_REG_W-1:0]  reg_idx;
      logic [HWP_WSEL_W-1:0] word_sel;
      logic [HWP_DATA_W-1:0] data;
   } hwp_wr_s;

   typedef enum logic [2:0] {
      HWP_IDLE  = 3'b001,
      HWP_ACT   = 3'b010,
      HWP_RECOV = 3'b100
   } hwp_state_e;
endpackage

// File: hw/hwp_sync.sv
`timescale 1ns/1ns
`default_nettype none
// Three-stage synchroniser; the output moves once stages two and three agree.
module hwp_sync
   import hwp_pkg::*;
#(
   parameter int   WIDTH = 1,
   parameter logic INIT  = 1'b0
) (
   input  wire logic             i_clk_sys,
   input  wire logic             i_rst,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] s1, s2, s3, next_out;

   always_comb begin
      for (int i = 0; i < WIDTH; i++) begin
         next_out[i] = (s2[i] == s3[i]) ? s3[i] : o_sync[i];
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         s1     <= {WIDTH{INIT}};
         s2     <= {WIDTH{INIT}};
         s3     <= {WIDTH{INIT}};
         o_sync <= {WIDTH{INIT}};
      end else begin
         s1     <= i_async;
         s2     <= s1;
         s3     <= s2;
         o_sync <= next_out;
      end
   end
endmodule
`default_nettype wire

// File: hw/hwp_write_port.sv
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - A write is live only while chip select and write strobe are both low, ends when either rises, either order.
// - With FIFO-direct selected, upper address bits are not decoded and every write goes to the transmit FIFO.
// - FIFO-direct applies per access, exactly when its select is high during that write.
// - In 16-bit bus mode data bits 31 to 16 are ignored, with unchanged cycle timing.
// - FIFO-direct writes still pass A[2:1] in both bus widths and ignore A[7:3].
// - One write cycle type serves all writes in both bus widths.
module hwp_write_port
   import hwp_pkg::*;
(
   input  wire logic                  i_clk_sys,
   input  wire logic                  i_rst,
   input  wire logic                  i_chip_select_n,
   input  wire logic                  i_write_strobe_n,
   input  wire logic                  i_fifo_sel,
   input  wire logic [HWP_ADDR_W-1:0] i_addr,
   input  wire logic [HWP_DATA_W-1:0] i_data,
   input  wire logic                  i_bus16,
   output logic                       o_reg_wr,
   output logic                       o_fifo_wr,
   output hwp_wr_s                    o_wr,
   output logic                       o_short_err
);
   logic       cs_n, wr_n;
   hwp_bus_s   bus_pin, bus_q, bus_hold, next_hold;
   hwp_state_e state, next_state;
   logic [3:0] cnt, next_cnt;
   logic       live;
   logic       commit;
   logic       bus16;
   logic       next_reg_wr, next_fifo_wr, next_short;
   hwp_wr_s    next_wr;

   hwp_sync #(.WIDTH(1), .INIT(HWP_PIN_IDLE)) u_cs (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .i_async   (i_chip_select_n),
      .o_sync    (cs_n)
   );
   hwp_sync #(.WIDTH(1), .INIT(HWP_PIN_IDLE)) u_wr (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .i_async   (i_write_strobe_n),
      .o_sync    (wr_n)
   );

   // Bus width strap is a pin as well; sampled like the strobes
   hwp_sync #(.WIDTH(1), .INIT(1'b0)) u_bus16 (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .i_async   (i_bus16),
      .o_sync    (bus16)
   );

   // Bus lines lag the strobes by the same three stages, so the sample
   // taken at the strobe edge is still within the data window.
   assign bus_pin = '{addr: i_addr, fifo_sel: i_fifo_sel, data: i_data};
   hwp_sync #(.WIDTH($bits(hwp_bus_s)), .INIT(1'b0)) u_bus (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .i_async   (bus_pin),
      .o_sync    (bus_q)
   );

   assign live   = !cs_n && !wr_n;
   assign commit = (state == HWP_ACT) && !live;

   // Control group: framing, active-time count and the bus sample
   always_comb begin
      next_state = state;
      next_cnt   = cnt;
      next_hold  = bus_hold;
      unique case (state)
         HWP_IDLE: begin
            next_cnt = 4'h0;
            if (live) begin
               // Sample on entry too, or a one-clock cycle commits stale data
               next_hold  = bus_q;
               next_state = HWP_ACT;
            end
         end
         HWP_ACT: begin
            if (cnt != 4'hf) begin
               next_cnt = cnt + 4'h1;
            end
            if (live) begin
               next_hold = bus_q;
            end else begin
               next_state = HWP_RECOV;
               next_cnt   = 4'h0;
            end
         end
         HWP_RECOV: begin
            // Idle time guard so a glitch cannot start a second write
            if (cnt != 4'hf) begin
               next_cnt = cnt + 4'h1;
            end
            if (cnt >= 4'(HWP_TCSH_CYC - 1) && !live) begin
               next_state = HWP_IDLE;
            end
         end
         default: next_state = HWP_IDLE;
      endcase
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         state    <= HWP_IDLE;
         cnt      <= 4'h0;
         bus_hold <= '0;
      end else begin
         state    <= next_state;
         cnt      <= next_cnt;
         bus_hold <= next_hold;
      end
   end

   // Commit group: one pulse per ended cycle, from the last live sample
   always_comb begin
      next_reg_wr  = 1'b0;
      next_fifo_wr = 1'b0;
      next_short   = 1'b0;
      next_wr      = o_wr;
      if (commit) begin
         // The clock spent leaving idle is not counted, hence the minus one
         next_short       = (cnt < 4'(HWP_TCSL_CYC - 1));
         next_fifo_wr     = bus_hold.fifo_sel;
         next_reg_wr      = !bus_hold.fifo_sel;
         next_wr.fifo     = bus_hold.fifo_sel;
         next_wr.word_sel = bus_hold.addr[HWP_WSEL_HI:HWP_WSEL_LO];
         next_wr.reg_idx  = bus_hold.fifo_sel ? '0 :
                            bus_hold.addr[HWP_REG_HI:HWP_REG_LO];
         next_wr.data     = bus16 ?
            {{HWP_HALF_W{1'b0}}, bus_hold.data[HWP_HALF_W-1:0]} : bus_hold.data;
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_reg_wr    <= 1'b0;
         o_fifo_wr   <= 1'b0;
         o_short_err <= 1'b0;
         o_wr        <= '0;
      end else begin
         o_reg_wr    <= next_reg_wr;
         o_fifo_wr   <= next_fifo_wr;
         o_short_err <= next_short;
         o_wr        <= next_wr;
      end
   end

   a_one_commit: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      !(o_reg_wr && o_fifo_wr))
      else $error("register and fifo write together");

   a_no_double: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (o_reg_wr || o_fifo_wr) |=> !(o_reg_wr || o_fifo_wr))
      else $error("two commits in a row");

   a_end_commit: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (state == HWP_ACT && !live) |=> (o_reg_wr || o_fifo_wr))
      else $error("cycle end without commit");

   a_fifo_route: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      o_fifo_wr |-> (o_wr.fifo && o_wr.reg_idx == '0))
      else $error("fifo write decoded address");

   a_sel_follows: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (state == HWP_ACT && !live) |=> (o_fifo_wr == $past(bus_hold.fifo_sel)))
      else $error("fifo select not honoured");

   a_half_mask: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (state == HWP_ACT && !live && bus16) |=> (o_wr.data[HWP_DATA_W-1:HWP_HALF_W] == '0))
      else $error("upper half not ignored");

   a_word_sel: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (state == HWP_ACT && !live) |=> (o_wr.word_sel == $past(bus_hold.addr[HWP_WSEL_HI:HWP_WSEL_LO])))
      else $error("word select lost");

   a_recov_hold: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (o_reg_wr || o_fifo_wr) |-> state == HWP_RECOV ##1 state != HWP_ACT)
      else $error("recovery skipped");

   a_idle_quiet: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (state == HWP_IDLE && $past(state) == HWP_IDLE) |-> !(o_reg_wr || o_fifo_wr))
      else $error("commit without cycle");

   a_hold_track: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (state == HWP_ACT && live) |=> (bus_hold == $past(bus_q)))
      else $error("live sample not taken");

   a_entry_sample: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (state == HWP_IDLE && live) |=> (state == HWP_ACT && bus_hold == $past(bus_q)))
      else $error("first live sample lost");

   a_reg_decode: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (commit && !bus_hold.fifo_sel) |=> (o_reg_wr && o_wr.reg_idx == $past(bus_hold.addr[HWP_REG_HI:HWP_REG_LO])))
      else $error("register write not decoded");

   a_fifo_steer: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (commit && bus_hold.fifo_sel) |=> (o_fifo_wr && !o_reg_wr))
      else $error("fifo write not steered");

   a_full_data: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (commit && !bus16) |=> (o_wr.data == $past(bus_hold.data)))
      else $error("full width data lost");

   a_low_half: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      (commit && bus16) |=> (o_wr.data[HWP_HALF_W-1:0] == $past(bus_hold.data[HWP_HALF_W-1:0])))
      else $error("lower half lost");

   a_wr_stands: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      !commit |=> $stable(o_wr))
      else $error("write payload moved without commit");

   a_short_flag: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      o_short_err |-> (o_reg_wr || o_fifo_wr))
      else $error("short flag without commit");
endmodule
`default_nettype wire

// File: sim/hwp_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// Host side: changes pins at the falling edge only
module hwp_host_model
   import hwp_pkg::*;
(
   input  wire logic                  i_clk_sys,
   output logic                       o_chip_select_n,
   output logic                       o_write_strobe_n,
   output logic                       o_fifo_sel,
   output logic      [HWP_ADDR_W-1:0] o_addr,
   output logic      [HWP_DATA_W-1:0] o_data
);
   initial begin
      o_chip_select_n  = 1'b1;
      o_write_strobe_n = 1'b1;
      o_fifo_sel       = 1'b0;
      o_addr           = '0;
      o_data           = '0;
   end

   task automatic write(input hwp_bus_s b, input int lowc, input bit cs_first);
      @(negedge i_clk_sys);
      o_addr     = b.addr;
      o_fifo_sel = b.fifo_sel;
      o_data     = b.data;
      if (cs_first) o_chip_select_n = 1'b0; else o_write_strobe_n = 1'b0;
      @(negedge i_clk_sys);
      o_chip_select_n  = 1'b0;
      o_write_strobe_n = 1'b0;
      repeat (lowc) @(negedge i_clk_sys);
      if (cs_first) o_chip_select_n = 1'b1; else o_write_strobe_n = 1'b1;
      @(negedge i_clk_sys);
      o_chip_select_n  = 1'b1;
      o_write_strobe_n = 1'b1;
      // Released bus shows garbage, never the old value
      o_addr     = ~b.addr;
      o_fifo_sel = ~b.fifo_sel;
      o_data     = ~b.data;
      repeat (4) @(negedge i_clk_sys);
   endtask
endmodule
`default_nettype wire

// File: sim/tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin miscompares++; \
   $display("mismatch at %0t: got %0h expected %0h", $time, (a), (b)); end end
module tb
   import hwp_pkg::*;
;
   logic                  clk;
   logic                  rst;
   logic                  cs_n;
   logic                  wr_n;
   logic                  fsel;
   logic [HWP_ADDR_W-1:0] addr;
   logic [HWP_DATA_W-1:0] data;
   logic                  bus16;
   logic                  reg_wr;
   logic                  fifo_wr;
   hwp_wr_s               wr;
   logic                  short_err;
   int                    miscompares;
   int                    samples_checked;
   int                    cycles;
   hwp_wr_s               exp_q[$];
   bit                    err_q[$];

   hwp_host_model hwp_host_model_inst (.i_clk_sys(clk), .o_chip_select_n(cs_n), .o_write_strobe_n(wr_n),
      .o_fifo_sel(fsel), .o_addr(addr), .o_data(data));
   hwp_write_port hwp_write_port_inst (.i_clk_sys(clk), .i_rst(rst), .i_chip_select_n(cs_n),
      .i_write_strobe_n(wr_n), .i_fifo_sel(fsel), .i_addr(addr), .i_data(data), .i_bus16(bus16),
      .o_reg_wr(reg_wr), .o_fifo_wr(fifo_wr), .o_wr(wr), .o_short_err(short_err));

   task automatic test_done;
      if (miscompares == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #(HWP_CLK_NS / 2) clk = ~clk;
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 8000) begin
         miscompares++;
         test_done();
      end
   end

   // Every commit pulse is matched against the oldest expected write
   always @(negedge clk) begin
      if (reg_wr === 1'b1 || fifo_wr === 1'b1) begin
         if (exp_q.size() == 0) begin
            `CHK(1'b1, 1'b0)
         end else begin
            `CHK({fifo_wr, reg_wr}, {exp_q[0].fifo, ~exp_q[0].fifo})
            `CHK(wr, exp_q[0])
            `CHK(short_err, err_q[0])
            void'(exp_q.pop_front());
            void'(err_q.pop_front());
         end
      end
   end

   initial begin
      hwp_bus_s b;
      hwp_wr_s  e;
      int       lowc;
      miscompares = 0;
      samples_checked = 0;
      cycles = 0;
      rst = 1'b1;
      bus16 = 1'b0;
      void'($urandom(32'h77f2));
      repeat (3) @(negedge clk);
      rst = 1'b0;
      for (int i = 0; i < 48; i++) begin
         bus16 = (i >= 24);
         {b.addr, b.fifo_sel} = 8'($urandom);
         b.data = $urandom;
         lowc = (i % 6 == 0) ? 1 : 2 + int'($urandom % 3);
         e.fifo = b.fifo_sel;
         e.reg_idx = b.fifo_sel ? '0 : b.addr[HWP_REG_HI:HWP_REG_LO];
         e.word_sel = b.addr[HWP_WSEL_HI:HWP_WSEL_LO];
         e.data = bus16 ? {16'h0000, b.data[HWP_HALF_W-1:0]} : b.data;
         exp_q.push_back(e);
         err_q.push_back(lowc < 2);
         hwp_host_model_inst.write(b, lowc, i[0]);
      end
      repeat (10) @(negedge clk);
      `CHK(exp_q.size(), 0)
      test_done();
   end
endmodule
`default_nettype wire
